// ===== verilog/dual_down_counter_timer_defs.svh
// constants for the dual down-counting counter/timer: register map, fields, pins and modes
`ifndef DUAL_DOWN_COUNTER_TIMER_DEFS_SVH
`define DUAL_DOWN_COUNTER_TIMER_DEFS_SVH

// counter width and mode encodings
`define CNT_W 24
`define MODE_W 3
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE 3'h2
`define MODE_SQUARE 3'h3
`define MODE_STROBE 3'h5

// register byte offsets, decoded on the low address bits
`define ADDR_W 8
`define ADDR_CTRL_A 8'h00
`define ADDR_LOAD_A 8'h04
`define ADDR_CTRL_B 8'h08
`define ADDR_LOAD_B 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_COUNT_A 8'h14
`define ADDR_COUNT_B 8'h18
`define ADDR_PIN_DIR 8'h1c
`define ADDR_PIN_OUT 8'h20
`define ADDR_PIN_IN 8'h24

// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_GATE_PIN_BIT 3
`define CTRL_SW_GATE_BIT 4
`define CTRL_OUT_ROUTE_BIT 5

// status register fields
`define STAT_OUT_A_BIT 0
`define STAT_OUT_B_BIT 1
`define STAT_RUN_A_BIT 2
`define STAT_RUN_B_BIT 3
`define STAT_GATE_A_BIT 4
`define STAT_GATE_B_BIT 5

// shared digital pins: two ports of eight
`define PIN_W 16
`define PORT_W 8
`define PORT_LO 0
`define PORT_HI 1
`define GATE_A_PIN 0
`define GATE_B_PIN 1
`define OUT_A_PIN 8
`define OUT_B_PIN 9

// bus encodings
`define DATA_W 32
`define HRESP_OKAY 1'h0

`endif

// ===== verilog/dual_down_counter_timer_pkg.sv
// types for the dual down-counting counter/timer
`include "dual_down_counter_timer_defs.svh"

package dual_down_counter_timer_pkg;

    // one counter channel; outLow is stored inverted so a zero reset leaves the output high
    typedef struct packed {
        logic [`CNT_W-1:0] count;
        logic outLow;
        logic running;
        logic gatePrev;
    } chan_s;

    // software control of one channel
    typedef struct packed {
        logic [`MODE_W-1:0] mode;
        logic gatePin;
        logic swGate;
        logic outRoute;
    } ctrl_s;

    // whole state of the block
    typedef struct packed {
        ctrl_s ctrlA;
        ctrl_s ctrlB;
        logic [`CNT_W-1:0] loadA;
        logic [`CNT_W-1:0] loadB;
        chan_s chA;
        chan_s chB;
        logic [1:0] portOut;
        logic [`PIN_W-1:0] pinData;
        logic [`PIN_W-1:0] pinMeta;
        logic [`PIN_W-1:0] pinSync;
        logic [1:0] clkMeta;
        logic [1:0] clkSync;
        logic [1:0] clkPrev;
        logic wrPend;
        logic [`ADDR_W-1:0] wrAddr;
        logic [`DATA_W-1:0] rdata;
        logic [`PIN_W-1:0] pinOut;
        logic [`PIN_W-1:0] pinOe;
    } state_s;

endpackage

// ===== verilog/dual_down_counter_timer.sv
// dual down-counting counter/timer with AHB-Lite registers and shared digital pins
// What this block does
// - two independent counters, each with one clock, one gate and one output.
// - counter_a counts edges of the analog input sample clock, not the multiplied clock.
// - counter_b counts edges of the analog output clock, two or four times converter rate.
// - each gate comes from a software bit or a shared input pin, selectable.
// - each output is readable in status and optionally routed to a shared pin.
// - a counter output reaches its pin only while that pin's port is output.
// - a gate is taken from its pin only while that pin's port is input.
// - each counter takes a load value of up to 24 bits, in clock periods.
// - one shot: gate rise drives output low and counts; high at expiry; retriggerable.
// - rate generator: counts while gate high; one-clock low pulse each expiry; reloads.
// - square wave: low from half the load value, high at expiry, then reloads.
// - strobe: gate rise starts counting; at expiry output pulses low one clock.
// - shared pins form two 8-bit ports, each with one direction setting.
`timescale 1ns/10ps
`include "dual_down_counter_timer_defs.svh"

module dual_down_counter_timer (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic aiSampleClk,
    input wire logic aoClk,
    input wire logic [15:0] pinIn,
    output logic [15:0] pinOut,
    output logic [15:0] pinOe
);

    dual_down_counter_timer_pkg::state_s st;
    dual_down_counter_timer_pkg::state_s nx;
    logic tickA;
    logic tickB;
    logic gateA;
    logic gateB;
    logic accept;

    // advance one channel by one step; in a counting mode only ticks move the count, an unsupported mode clears it
    function automatic dual_down_counter_timer_pkg::chan_s chan_step(
        input dual_down_counter_timer_pkg::chan_s c,
        input dual_down_counter_timer_pkg::ctrl_s k,
        input logic [`CNT_W-1:0] load,
        input logic tick,
        input logic gate
    );
        dual_down_counter_timer_pkg::chan_s n;
        logic rise;
        logic expire;
        logic [`CNT_W-1:0] dec;
        n = c;
        rise = gate & ~c.gatePrev;
        expire = (c.count <= `CNT_W'(1));
        dec = c.count - `CNT_W'(1);
        if (tick) begin
            n.gatePrev = gate;
        end
        case (k.mode)
            `MODE_ONE_SHOT: begin
                if (tick) begin
                    if (rise) begin
                        n.count = load;
                        n.outLow = 1'b1;
                        n.running = 1'b1;
                    end else if (c.running) begin
                        if (expire) begin
                            n.count = '0;
                            n.outLow = 1'b0;
                            n.running = 1'b0;
                        end else begin
                            n.count = dec;
                        end
                    end
                end
            end
            `MODE_RATE: begin
                n.running = gate;
                if (!gate) begin
                    n.outLow = 1'b0;
                end else if (tick) begin
                    if (expire) begin
                        n.count = load;
                        n.outLow = 1'b1;
                    end else begin
                        n.count = dec;
                        n.outLow = 1'b0;
                    end
                end
            end
            `MODE_SQUARE: begin
                n.running = gate;
                if (!gate) begin
                    n.outLow = 1'b0;
                end else if (tick) begin
                    if (expire) begin
                        n.count = load;
                        n.outLow = 1'b0;
                    end else begin
                        n.count = dec;
                        if (dec == (load >> 1)) begin
                            n.outLow = 1'b1;
                        end
                    end
                end
            end
            `MODE_STROBE: begin
                if (tick) begin
                    n.outLow = 1'b0;
                    if (rise) begin
                        n.count = load;
                        n.running = 1'b1;
                    end else if (c.running) begin
                        if (expire) begin
                            n.count = '0;
                            n.outLow = 1'b1;
                            n.running = 1'b0;
                        end else begin
                            n.count = dec;
                        end
                    end
                end
            end
            default: begin
                n.count = '0;
                n.outLow = 1'b0;
                n.running = 1'b0;
            end
        endcase
        return n;
    endfunction

    // pack a control register into a bus word
    function automatic logic [`DATA_W-1:0] ctrl_word(input dual_down_counter_timer_pkg::ctrl_s k);
        logic [`DATA_W-1:0] w;
        w = '0;
        w[`CTRL_MODE_LSB +: `MODE_W] = k.mode;
        w[`CTRL_GATE_PIN_BIT] = k.gatePin;
        w[`CTRL_SW_GATE_BIT] = k.swGate;
        w[`CTRL_OUT_ROUTE_BIT] = k.outRoute;
        return w;
    endfunction

    // unpack a bus word into a control register
    function automatic dual_down_counter_timer_pkg::ctrl_s ctrl_from(input logic [`DATA_W-1:0] w);
        dual_down_counter_timer_pkg::ctrl_s k;
        k.mode = w[`CTRL_MODE_LSB +: `MODE_W];
        k.gatePin = w[`CTRL_GATE_PIN_BIT];
        k.swGate = w[`CTRL_SW_GATE_BIT];
        k.outRoute = w[`CTRL_OUT_ROUTE_BIT];
        return k;
    endfunction

    // gate source: a pin is only honoured while its port is input, otherwise reads low
    function automatic logic gate_pick(
        input dual_down_counter_timer_pkg::ctrl_s k,
        input logic portIsOut,
        input logic pinLevel
    );
        return k.gatePin ? (~portIsOut & pinLevel) : k.swGate;
    endfunction

    // edges of the synchronised counter clocks; the clocks must be slower than a quarter of sys_clk
    assign tickA = st.clkSync[0] & ~st.clkPrev[0];
    assign tickB = st.clkSync[1] & ~st.clkPrev[1];
    assign gateA = gate_pick(st.ctrlA, st.portOut[`PORT_LO], st.pinSync[`GATE_A_PIN]);
    assign gateB = gate_pick(st.ctrlB, st.portOut[`PORT_LO], st.pinSync[`GATE_B_PIN]);
    assign accept = hsel & hready & htrans[1] & clkEn;

    // zero-wait slave; a low clock enable stalls the bus rather than dropping a transfer
    assign hreadyout = clkEn;
    assign hresp = `HRESP_OKAY;
    assign hrdata = st.rdata;
    assign pinOut = st.pinOut;
    assign pinOe = st.pinOe;

    // next-state logic for the whole block
    always_comb begin
        logic [`DATA_W-1:0] rd;
        logic [`PIN_W-1:0] pinView;
        rd = '0;
        pinView = '0;
        nx = st;
        // two-flop synchronisers for the foreign clocks and pins
        nx.clkMeta = {aoClk, aiSampleClk};
        nx.clkSync = st.clkMeta;
        nx.clkPrev = st.clkSync;
        nx.pinMeta = pinIn;
        nx.pinSync = st.pinMeta;
        // data phase of a write lands before this cycle's read is sampled
        nx.wrPend = accept & hwrite;
        if (accept) begin
            nx.wrAddr = haddr[`ADDR_W-1:0];
        end
        if (st.wrPend) begin
            case (st.wrAddr)
                `ADDR_CTRL_A: nx.ctrlA = ctrl_from(hwdata);
                `ADDR_CTRL_B: nx.ctrlB = ctrl_from(hwdata);
                `ADDR_LOAD_A: nx.loadA = hwdata[`CNT_W-1:0];
                `ADDR_LOAD_B: nx.loadB = hwdata[`CNT_W-1:0];
                `ADDR_PIN_DIR: nx.portOut = hwdata[1:0];
                `ADDR_PIN_OUT: nx.pinData = hwdata[`PIN_W-1:0];
                default: nx.pinData = nx.pinData; // unmapped writes are ignored
            endcase
        end
        // counters run independently on their own ticks
        nx.chA = chan_step(st.chA, st.ctrlA, st.loadA, tickA, gateA);
        nx.chB = chan_step(st.chB, st.ctrlB, st.loadB, tickB, gateB);
        // pin drivers: one enable per port, counter outputs replace plain data when routed
        nx.pinOe = {{`PORT_W{nx.portOut[`PORT_HI]}}, {`PORT_W{nx.portOut[`PORT_LO]}}};
        nx.pinOut = nx.pinData;
        if (nx.ctrlA.outRoute) begin
            nx.pinOut[`OUT_A_PIN] = ~nx.chA.outLow;
        end
        if (nx.ctrlB.outRoute) begin
            nx.pinOut[`OUT_B_PIN] = ~nx.chB.outLow;
        end
        // an output port reads back the state it drives
        pinView = (nx.pinOut & nx.pinOe) | (st.pinSync & ~nx.pinOe);
        // read data sampled in the address phase from the updated state
        case (haddr[`ADDR_W-1:0])
            `ADDR_CTRL_A: rd = ctrl_word(nx.ctrlA);
            `ADDR_CTRL_B: rd = ctrl_word(nx.ctrlB);
            `ADDR_LOAD_A: rd[`CNT_W-1:0] = nx.loadA;
            `ADDR_LOAD_B: rd[`CNT_W-1:0] = nx.loadB;
            `ADDR_COUNT_A: rd[`CNT_W-1:0] = nx.chA.count;
            `ADDR_COUNT_B: rd[`CNT_W-1:0] = nx.chB.count;
            `ADDR_STATUS: begin
                rd[`STAT_OUT_A_BIT] = ~nx.chA.outLow;
                rd[`STAT_OUT_B_BIT] = ~nx.chB.outLow;
                rd[`STAT_RUN_A_BIT] = nx.chA.running;
                rd[`STAT_RUN_B_BIT] = nx.chB.running;
                rd[`STAT_GATE_A_BIT] = gateA;
                rd[`STAT_GATE_B_BIT] = gateB;
            end
            `ADDR_PIN_DIR: rd[1:0] = nx.portOut;
            `ADDR_PIN_OUT: rd[`PIN_W-1:0] = nx.pinData;
            `ADDR_PIN_IN: rd[`PIN_W-1:0] = pinView;
            default: rd = '0;
        endcase
        if (accept && !hwrite) begin
            nx.rdata = rd;
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else if (clkEn) begin
            st <= nx;
        end
    end

    // an unmapped read answers zero in its data phase
    a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (reset)
        (accept && !hwrite && haddr[`ADDR_W-1:0] > `ADDR_PIN_IN) |=> (hrdata == '0))
        else $error("unmapped read did not return zero");

    // one-shot trigger loads the count and drives the output low
    a_oneshot_trigger: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_ONE_SHOT && tickA && gateA && !st.chA.gatePrev)
        |=> (pinOut[`OUT_A_PIN] == 1'b0 || !st.ctrlA.outRoute) && st.chA.outLow && st.chA.count == $past(st.loadA))
        else $error("one shot did not start on gate rise");

    // a rate-generator pulse coincides with a fresh reload
    a_rate_pulse_reload: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_RATE && tickA && gateA && st.chA.count <= 24'h000001)
        |=> st.chA.outLow && st.chA.count == $past(st.loadA))
        else $error("rate generator missed its pulse or reload");

    // rate-generator pulse lasts exactly one counter clock
    a_rate_pulse_width: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_RATE && st.chA.outLow && tickA && gateA && st.chA.count > 24'h000001)
        |=> !st.chA.outLow)
        else $error("rate generator pulse longer than one clock");

    // square wave drops at half the load value
    a_square_half: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_SQUARE && tickA && gateA && st.chA.count > 24'h000001
        && (st.chA.count - 24'h000001) == (st.loadA >> 1)) |=> st.chA.outLow)
        else $error("square wave did not go low at half count");

    // strobe output is low only once the run has ended
    a_strobe_end: assert property (@(posedge sys_clk) disable iff (reset)
        (st.ctrlA.mode == `MODE_STROBE && st.chA.outLow) |-> !st.chA.running)
        else $error("strobe pulsed while still counting");

    // the strobe pulse lasts a single counter clock
    a_strobe_pulse_one: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_STROBE && st.chA.outLow && tickA) |=> !st.chA.outLow)
        else $error("strobe pulse longer than one clock");

    // a one-shot run that expires without a fresh trigger returns the output high
    a_oneshot_expire: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlA.mode == `MODE_ONE_SHOT && tickA && st.chA.running && !(gateA && !st.chA.gatePrev)
        && st.chA.count <= 24'h000001) |=> !st.chA.outLow && !st.chA.running)
        else $error("one shot did not end at expiry");

    // the second counter reloads and pulses on its own clock
    a_rate_b_reload: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlB.mode == `MODE_RATE && tickB && gateB && st.chB.count <= 24'h000001)
        |=> st.chB.outLow && st.chB.count == $past(st.loadB))
        else $error("second counter missed its pulse or reload");

    // a routed output shows the first counter's level on its pin
    a_route_pin_a: assert property (@(posedge sys_clk) disable iff (reset)
        st.ctrlA.outRoute |-> pinOut[`OUT_A_PIN] == !st.chA.outLow)
        else $error("first counter output not on its pin");

    // a routed output shows the second counter's level on its pin
    a_route_pin_b: assert property (@(posedge sys_clk) disable iff (reset)
        st.ctrlB.outRoute |-> pinOut[`OUT_B_PIN] == !st.chB.outLow)
        else $error("second counter output not on its pin");

    // an unsupported mode keeps the output high and the count cleared
    a_idle_mode_high: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && st.ctrlB.mode inside {3'h0, 3'h4, 3'h6, 3'h7}) |=> !st.chB.outLow && st.chB.count == '0)
        else $error("idle mode did not hold output high");

    // without a tick the count does not move in a counting mode
    a_count_tick_only: assert property (@(posedge sys_clk) disable iff (reset)
        (clkEn && !tickB && st.ctrlB.mode inside {`MODE_ONE_SHOT, `MODE_RATE, `MODE_SQUARE, `MODE_STROBE}
        && st.ctrlB.mode == nx.ctrlB.mode) |=> $stable(st.chB.count))
        else $error("count changed without a counter clock edge");

    // every pin of a port shares its enable
    a_port_direction: assert property (@(posedge sys_clk) disable iff (reset)
        (pinOe[15:8] == '0 || pinOe[15:8] == 8'hff) && (pinOe[7:0] == '0 || pinOe[7:0] == 8'hff))
        else $error("port pins disagree on direction");

    // a pin gate reads low while its port drives
    a_gate_pin_dir: assert property (@(posedge sys_clk) disable iff (reset)
        (st.ctrlA.gatePin && st.portOut[`PORT_LO]) |-> !gateA)
        else $error("gate taken from a pin of an output port");

endmodule // dual_down_counter_timer

// ===== testbench/pin_world.sv
// model of the outside world on the shared digital pins, plus the two sample clocks
`timescale 1ns/10ps

module pin_world #(
    parameter int AI_HALF = 4,
    parameter int AO_HALF = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe,
    input wire logic [1:0] gateDrive,
    output logic [15:0] pinIn,
    output logic aiSampleClk,
    output logic aoClk
);
    int aiCnt;
    int aoCnt;
    logic [15:0] fill;

    // free-running sample clocks; each phase spans several sys_clk periods so the sync never drops an edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aiCnt <= 0;
            aoCnt <= 0;
            aiSampleClk <= 1'b0;
            aoClk <= 1'b0;
            fill <= 16'h5a5a;
        end else begin
            aiCnt <= (aiCnt == AI_HALF - 1) ? 0 : aiCnt + 1;
            aoCnt <= (aoCnt == AO_HALF - 1) ? 0 : aoCnt + 1;
            if (aiCnt == AI_HALF - 1) aiSampleClk <= ~aiSampleClk;
            if (aoCnt == AO_HALF - 1) aoClk <= ~aoClk;
            fill <= ~fill;
        end
    end

    // wire level: the device wins where enabled; gate pins are driven from outside only while port0 is input,
    // and an undriven pin shows a toggling pattern rather than a stale level
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pinOe[i]) pinIn[i] = pinOut[i];
            else if (i < 2) pinIn[i] = gateDrive[i];
            else pinIn[i] = fill[i];
        end
    end
endmodule // pin_world

// ===== testbench/dual_down_counter_timer_bench.sv
// self-checking bench for the dual down-counting counter/timer
`timescale 1ns/10ps
`include "dual_down_counter_timer_defs.svh"

module dual_down_counter_timer_bench;
    localparam int PA = 8;
    localparam int PB = 12;
    logic sys_clk, reset, clkEn, hsel, hwrite, hready, hreadyout, hresp, aiSampleClk, aoClk;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans, gateDrive;
    logic [2:0] hsize;
    logic [15:0] pinIn, pinOut, pinOe;
    int n_fail, total_checks, lo, per, n;

    assign hready = hreadyout;

    dual_down_counter_timer i_dual_down_counter_timer (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .aiSampleClk(aiSampleClk),
        .aoClk(aoClk), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

    pin_world #(.AI_HALF(PA / 2), .AO_HALF(PB / 2)) i_pin_world (.sys_clk(sys_clk), .reset(reset),
        .pinOut(pinOut), .pinOe(pinOe), .gateDrive(gateDrive), .pinIn(pinIn), .aiSampleClk(aiSampleClk),
        .aoClk(aoClk));

    task test_done;
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task expect_true(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // single AHB-Lite transfers; the master waits for hready with no assumed latency
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
        expect_true(hresp === `HRESP_OKAY, "bus response not okay");
    endtask

    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        ahb(1'b1, a, wd, x);
    endtask

    function automatic logic [31:0] cw(logic [2:0] m, logic gp, logic sw, logic rt);
        return {26'h0, rt, sw, gp, m};
    endfunction

    // cycles until a pin reaches a level, capped at lim
    task wait_cnt(input int b, input logic v, input int lim, output int c);
        c = 0;
        while (pinOut[b] !== v && c < lim) begin
            @(posedge sys_clk);
            c++;
        end
    endtask

    task measure(input int b, output int l, output int p);
        int h;
        wait_cnt(b, 1'b1, 2000, h);
        wait_cnt(b, 1'b0, 2000, h);
        wait_cnt(b, 1'b1, 2000, l);
        wait_cnt(b, 1'b0, 2000, h);
        p = l + h;
    endtask

    task t_reset;
        ahb(1'b0, `ADDR_STATUS, 32'h0, d);
        expect_true(d[1:0] === 2'h3, "outputs not high after reset");
        expect_true(pinOe === 16'h0, "pins driven after reset");
        ahb(1'b0, 8'h28, 32'h0, d);
        expect_true(d === 32'h0, "unmapped read not zero");
        wr(`ADDR_LOAD_A, 32'hffffffff);
        ahb(1'b0, `ADDR_LOAD_A, 32'h0, d);
        expect_true(d === 32'h00ffffff, "load not 24 bits");
        wr(`ADDR_PIN_OUT, 32'ha5c3);
        wr(`ADDR_PIN_DIR, 32'h3);
        ahb(1'b0, `ADDR_PIN_IN, 32'h0, d);
        expect_true(d === 32'ha5c3, "output port readback wrong");
        wr(`ADDR_PIN_DIR, 32'h0);
        wr(`ADDR_PIN_OUT, 32'h0);
    endtask

    // both counters free-running at once on their own clocks
    task t_rate;
        wr(`ADDR_PIN_DIR, 32'h2);
        wr(`ADDR_LOAD_A, 32'h3);
        wr(`ADDR_LOAD_B, 32'h2);
        wr(`ADDR_CTRL_A, cw(`MODE_RATE, 1'b0, 1'b1, 1'b1));
        wr(`ADDR_CTRL_B, cw(`MODE_RATE, 1'b0, 1'b1, 1'b1));
        repeat (2) @(posedge sys_clk);
        expect_true(pinOe === 16'hff00, "port enables wrong");
        measure(`OUT_A_PIN, lo, per);
        expect_true(lo == PA && per == 3 * PA, "rate a pulse wrong");
        measure(`OUT_B_PIN, lo, per);
        expect_true(lo == PB && per == 2 * PB, "rate b pulse wrong");
        wr(`ADDR_CTRL_B, 32'h0);
    endtask

    task t_square;
        wr(`ADDR_LOAD_A, 32'h4);
        wr(`ADDR_CTRL_A, cw(`MODE_SQUARE, 1'b0, 1'b1, 1'b1));
        measure(`OUT_A_PIN, lo, per);
        expect_true(lo == 2 * PA && per == 4 * PA, "square wave wrong");
    endtask

    // gate taken from pin 0; retrigger stretches the low time
    task t_one_shot;
        gateDrive <= 2'h0;
        wr(`ADDR_LOAD_A, 32'h5);
        wr(`ADDR_CTRL_A, cw(`MODE_ONE_SHOT, 1'b1, 1'b0, 1'b1));
        repeat (4 * PA) @(posedge sys_clk);
        expect_true(pinOut[`OUT_A_PIN] === 1'b1, "one shot not resting high");
        gateDrive <= 2'h1;
        wait_cnt(`OUT_A_PIN, 1'b0, 10 * PA, n);
        ahb(1'b0, `ADDR_STATUS, 32'h0, d);
        expect_true(d[`STAT_GATE_A_BIT] === 1'b1, "pin gate not seen");
        wait_cnt(`OUT_A_PIN, 1'b1, 20 * PA, lo);
        expect_true(lo + n >= 4 * PA && lo + n <= 7 * PA, "one shot width wrong");
        gateDrive <= 2'h0;
        repeat (2 * PA) @(posedge sys_clk);
        gateDrive <= 2'h1;
        wait_cnt(`OUT_A_PIN, 1'b0, 10 * PA, n);
        repeat (2 * PA) @(posedge sys_clk);
        gateDrive <= 2'h0;
        repeat (2 * PA) @(posedge sys_clk);
        gateDrive <= 2'h1;
        wait_cnt(`OUT_A_PIN, 1'b1, 20 * PA, lo);
        expect_true(lo >= 3 * PA, "retrigger did not restart");
        wr(`ADDR_PIN_DIR, 32'h3);
        ahb(1'b0, `ADDR_STATUS, 32'h0, d);
        expect_true(d[`STAT_GATE_A_BIT] === 1'b0, "gate read from output port");
    endtask

    task t_strobe;
        wr(`ADDR_PIN_DIR, 32'h2);
        wr(`ADDR_CTRL_A, cw(`MODE_STROBE, 1'b0, 1'b0, 1'b1));
        wr(`ADDR_LOAD_A, 32'h4);
        wr(`ADDR_CTRL_A, cw(`MODE_STROBE, 1'b0, 1'b1, 1'b1));
        wait_cnt(`OUT_A_PIN, 1'b0, 10 * PA, n);
        expect_true(n >= 2 * PA && n < 10 * PA, "strobe delay wrong");
        wait_cnt(`OUT_A_PIN, 1'b1, 4 * PA, lo);
        expect_true(lo == PA, "strobe width wrong");
        wait_cnt(`OUT_A_PIN, 1'b0, 8 * PA, n);
        expect_true(n == 8 * PA, "strobe repeated");
    endtask

    task t_unsup;
        logic [2:0] modes [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
        foreach (modes[i]) begin
            wr(`ADDR_CTRL_A, cw(modes[i], 1'b0, 1'b1, 1'b1));
            repeat (4 * PA) @(posedge sys_clk);
            expect_true(pinOut[`OUT_A_PIN] === 1'b1, "idle mode output low");
            ahb(1'b0, `ADDR_COUNT_A, 32'h0, d);
            expect_true(d === 32'h0, "idle mode counting");
        end
        wr(`ADDR_PIN_DIR, 32'h0);
        repeat (2) @(posedge sys_clk);
        expect_true(pinOe === 16'h0, "output driven on input port");
    endtask

    // a low clock enable stalls the bus and freezes the counters, then they resume
    task t_freeze;
        wr(`ADDR_CTRL_A, cw(`MODE_RATE, 1'b0, 1'b1, 1'b1));
        repeat (5 * PA) @(posedge sys_clk);
        clkEn <= 1'b0;
        @(posedge sys_clk);
        wait_cnt(`OUT_A_PIN, ~pinOut[`OUT_A_PIN], 4 * PA, n);
        expect_true(n == 4 * PA, "output moved while clock enable low");
        expect_true(hreadyout === 1'b0, "bus not stalled by clock enable");
        clkEn <= 1'b1;
        wait_cnt(`OUT_A_PIN, ~pinOut[`OUT_A_PIN], 4 * PA, n);
        expect_true(n < 4 * PA, "output stuck after clock enable");
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // watchdog: the whole run needs well under this many cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_fail++;
        test_done;
    end

    initial begin
        n_fail = 0;
        total_checks = 0;
        reset = 1'b1;
        clkEn = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        gateDrive = 2'h0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_rate;
        t_square;
        t_one_shot;
        t_strobe;
        t_unsup;
        t_freeze;
        test_done;
    end
endmodule // dual_down_counter_timer_bench
